/* File: verilog/dma_channel_control.sv */
// Purpose: Eight-channel controller between peripherals and buffer RAM.
// Assumes: Peripheral requests are single-cycle pulses on this clock.
// Notes: Registers are reached over Avalon-MM with one wait cycle.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`default_nettype none
module dma_channel_control
#(
	parameter int NUM_CH = dma_pkg::NUM_CH
)
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [8:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic [15:0] IRQ_REQ_I,
	input wire logic [15:0] PERIPH_OFS_I,
	input wire logic [15:0] RAM_RDATA_I,
	input wire logic [15:0] PER_RDATA_I,
	output logic [15:0] RAM_ADDR_O,
	output logic [15:0] RAM_WDATA_O,
	output logic [1:0] RAM_BE_O,
	output logic RAM_WE_O,
	output logic RAM_RE_O,
	output logic [15:0] PER_ADDR_O,
	output logic [15:0] PER_WDATA_O,
	output logic [1:0] PER_BE_O,
	output logic PER_WE_O,
	output logic PER_RE_O,
	output logic INT_O
);
	localparam int CW = dma_pkg::CNT_W;

	logic [15:0] ctl_q [NUM_CH];
	logic [15:0] sel_q [NUM_CH];
	logic [15:0] sta_q [NUM_CH];
	logic [15:0] stb_q [NUM_CH];
	logic [15:0] pad_q [NUM_CH];
	logic [CW-1:0] cnt_q [NUM_CH];
	logic [CW-1:0] idx_q [NUM_CH];
	logic [NUM_CH-1:0] pp_q;
	logic [NUM_CH-1:0] pend_q;
	logic [15:0] st0_q;
	logic [15:0] mask_q;
	logic wait_q;
	logic busy_q;
	logic start_q;
	logic [2:0] act_q;
	logic [31:0] rdata_q;
	logic irq_q;
	logic mv_done;
	logic [15:0] rd_mux;

	// Merges the two low byte lanes of a write into a 16-bit register.
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction : merge

	// Lowest-numbered set bit of a channel vector.
	function automatic logic [2:0] first_set(input logic [7:0] v);
		first_set = 3'h0;
		for (int i = 7; i >= 0; i--)
		begin
			if (v[i])
				first_set = i[2:0];
		end
	endfunction : first_set

	// Bus decode.
	wire req = AVS_READ_I | AVS_WRITE_I;
	wire do_wr = AVS_WRITE_I & ~wait_q;
	wire shared = AVS_ADDRESS_I[dma_pkg::SHARED_BIT];
	wire [2:0] wr_ch = AVS_ADDRESS_I[dma_pkg::CH_LSB +: 3];
	wire [2:0] wr_reg = AVS_ADDRESS_I[dma_pkg::REG_LSB +: 3];
	wire wr_chan = do_wr & ~shared & (AVS_ADDRESS_I[1:0] == 2'h0);
	wire wr_st0 = do_wr & (AVS_ADDRESS_I == dma_pkg::OFS_STAT0);
	wire wr_mask = do_wr & (AVS_ADDRESS_I == dma_pkg::OFS_MASK);

	// Request detection and arbitration.
	logic [NUM_CH-1:0] hit;
	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
			hit[c] = ctl_q[c][dma_pkg::CTL_EN] &
				IRQ_REQ_I[sel_q[c][dma_pkg::SEL_W-1:0]];
	end
	wire [NUM_CH-1:0] ovr = hit & pend_q;
	wire grant = ~busy_q & ~start_q & (|pend_q);
	wire [2:0] gch = first_set(pend_q);

	// Address generation for the active channel.
	wire [15:0] a_ctl = ctl_q[act_q];
	wire [1:0] addr_mode = a_ctl[dma_pkg::CTL_ADDR_MODE_LO +: 2];
	wire [1:0] mode = a_ctl[dma_pkg::CTL_MODE_LO +: 2];
	wire pingpong = mode[dma_pkg::MODE_PINGPONG];
	wire oneshot = mode[dma_pkg::MODE_ONESHOT];
	wire a_byte = a_ctl[dma_pkg::CTL_SIZE];
	wire [15:0] base = (pingpong & pp_q[act_q]) ? stb_q[act_q]
		: sta_q[act_q];
	wire [15:0] idx_ext = {6'h00, idx_q[act_q]};
	wire [15:0] step_ofs = a_byte ? idx_ext : {idx_ext[14:0], 1'b0};
	wire [15:0] ofs = (addr_mode == dma_pkg::AM_NOINC) ? 16'h0000
		: (addr_mode == dma_pkg::AM_PERIPH) ? PERIPH_OFS_I : step_ofs;
	wire [15:0] ram_addr = base + ofs;

	// Element and block bookkeeping.
	wire [CW:0] moved = {1'b0, idx_q[act_q]} + 11'h001;
	wire [CW:0] total = {1'b0, cnt_q[act_q]} + 11'h001;
	wire [CW:0] half = (total + 11'h001) >> 1;
	wire last = moved == total;
	wire blk_evt = mv_done & (a_ctl[dma_pkg::CTL_HALF] ? (moved == half)
		: last);
	wire final_blk = oneshot & (~pingpong | pp_q[act_q]);

	always_comb
	begin
		rd_mux = 16'h0000;
		if (shared)
		begin
			if (AVS_ADDRESS_I == dma_pkg::OFS_STAT0)
				rd_mux = st0_q;
			else if (AVS_ADDRESS_I == dma_pkg::OFS_STAT1)
			begin
				rd_mux[2:0] = act_q;
				rd_mux[dma_pkg::ST1_BUSY] = busy_q;
				rd_mux[dma_pkg::ST1_PP_LO +: 8] = pp_q;
			end
			else if (AVS_ADDRESS_I == dma_pkg::OFS_MASK)
				rd_mux = mask_q;
		end
		else if (AVS_ADDRESS_I[1:0] == 2'h0)
		begin
			case (wr_reg)
				dma_pkg::REG_CTL: rd_mux = ctl_q[wr_ch] & dma_pkg::CTL_WMASK;
				dma_pkg::REG_SEL: rd_mux = sel_q[wr_ch];
				dma_pkg::REG_STA: rd_mux = sta_q[wr_ch];
				dma_pkg::REG_STB: rd_mux = stb_q[wr_ch];
				dma_pkg::REG_PAD: rd_mux = pad_q[wr_ch];
				dma_pkg::REG_CNT: rd_mux = {6'h00, cnt_q[wr_ch]};
				default: rd_mux = 16'h0000;
			endcase
		end
	end

	// Avalon slave: one wait cycle, read data captured with it.
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			wait_q <= ~(req & wait_q);
			if (AVS_READ_I & wait_q)
				rdata_q <= {16'h0000, rd_mux};
		end
	end

	// Channel registers and per-channel state.
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			for (int c = 0; c < NUM_CH; c++)
			begin
				ctl_q[c] <= dma_pkg::REG_RST;
				sel_q[c] <= dma_pkg::REG_RST;
				sta_q[c] <= dma_pkg::REG_RST;
				stb_q[c] <= dma_pkg::REG_RST;
				pad_q[c] <= dma_pkg::REG_RST;
				cnt_q[c] <= dma_pkg::CNT_RST;
				idx_q[c] <= dma_pkg::CNT_RST;
			end
			pp_q <= 8'h00;
			pend_q <= 8'h00;
		end
		else
		begin
			for (int c = 0; c < NUM_CH; c++)
			begin
				// A new request wins over the clear at grant.
				pend_q[c] <= hit[c] |
					(pend_q[c] & ~(grant & (gch == c[2:0])));
				if (mv_done & (act_q == c[2:0]))
				begin
					if (last)
					begin
						idx_q[c] <= dma_pkg::CNT_RST;
						if (pingpong)
							pp_q[c] <= ~pp_q[c];
						if (final_blk)
							ctl_q[c][dma_pkg::CTL_EN] <= 1'b0;
					end
					else
						idx_q[c] <= moved[CW-1:0];
				end
				if (wr_chan & (wr_ch == c[2:0]))
				begin
					case (wr_reg)
						dma_pkg::REG_CTL:
						begin
							ctl_q[c] <= merge(ctl_q[c], AVS_WRITEDATA_I,
								AVS_BYTEENABLE_I) & dma_pkg::CTL_WMASK;
							idx_q[c] <= dma_pkg::CNT_RST;
							pp_q[c] <= 1'b0;
						end
						dma_pkg::REG_SEL: sel_q[c] <= merge(sel_q[c],
							AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
						dma_pkg::REG_STA: sta_q[c] <= merge(sta_q[c],
							AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
						dma_pkg::REG_STB: stb_q[c] <= merge(stb_q[c],
							AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
						dma_pkg::REG_PAD: pad_q[c] <= merge(pad_q[c],
							AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
						dma_pkg::REG_CNT:
							cnt_q[c] <= CW'(merge({6'h00, cnt_q[c]},
								AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
						default:
							cnt_q[c] <= cnt_q[c];
					endcase
				end
			end
		end
	end

	// Engine sequencing, shared status and interrupt.
	wire [15:0] evt = {ovr, 8'h00} | {8'h00, blk_evt ? (8'h01 << act_q) : 8'h00};
	wire [15:0] st0_clr = wr_st0 ? merge(16'h0000, AVS_WRITEDATA_I,
		AVS_BYTEENABLE_I) : 16'h0000;

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			busy_q <= 1'b0;
			start_q <= 1'b0;
			act_q <= 3'h0;
			st0_q <= dma_pkg::REG_RST;
			mask_q <= dma_pkg::REG_RST;
			irq_q <= 1'b0;
		end
		else
		begin
			start_q <= grant;
			if (grant)
			begin
				act_q <= gch;
				busy_q <= 1'b1;
			end
			else if (mv_done)
				busy_q <= 1'b0;
			st0_q <= evt | (st0_q & ~st0_clr);
			if (wr_mask)
				mask_q <= merge(mask_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			irq_q <= |(st0_q & mask_q);
		end
	end

	dma_mover u_mover
	(
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.start_i(start_q),
		.to_per_i(a_ctl[dma_pkg::CTL_DIR]),
		.byte_i(a_byte),
		.null_wr_i(a_ctl[dma_pkg::CTL_NULL_WR]),
		.ram_addr_i(ram_addr),
		.per_addr_i(pad_q[act_q]),
		.ram_rdata_i(RAM_RDATA_I),
		.per_rdata_i(PER_RDATA_I),
		.ram_addr_o(RAM_ADDR_O),
		.ram_wdata_o(RAM_WDATA_O),
		.ram_be_o(RAM_BE_O),
		.ram_we_o(RAM_WE_O),
		.ram_re_o(RAM_RE_O),
		.per_addr_o(PER_ADDR_O),
		.per_wdata_o(PER_WDATA_O),
		.per_be_o(PER_BE_O),
		.per_we_o(PER_WE_O),
		.per_re_o(PER_RE_O),
		.done_o(mv_done)
	);

	assign AVS_READDATA_O = rdata_q;
	assign AVS_WAITREQUEST_O = wait_q;
	assign INT_O = irq_q;
endmodule : dma_channel_control
`default_nettype wire

/* File: common/dma_pkg.sv */
// Purpose: Shared constants for the eight-channel transfer controller.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes: Registers are 16 bits wide and sit in the low half of the word.
`default_nettype none
package dma_pkg;
	localparam int NUM_CH = 8;
	localparam int CH_W = 3;
	localparam int ADDR_W = 9;
	localparam int CNT_W = 10;
	localparam int NUM_IRQ = 16;
	localparam int SEL_W = 4;

	// Channel window: bit 8 clear, channel in bits 7:5, register in 4:2.
	localparam logic [2:0] REG_CTL = 3'h0;
	localparam logic [2:0] REG_SEL = 3'h1;
	localparam logic [2:0] REG_STA = 3'h2;
	localparam logic [2:0] REG_STB = 3'h3;
	localparam logic [2:0] REG_PAD = 3'h4;
	localparam logic [2:0] REG_CNT = 3'h5;
	localparam int CH_LSB = 5;
	localparam int REG_LSB = 2;
	localparam int SHARED_BIT = 8;
	localparam logic [ADDR_W-1:0] OFS_STAT0 = 9'h100;
	localparam logic [ADDR_W-1:0] OFS_STAT1 = 9'h104;
	localparam logic [ADDR_W-1:0] OFS_MASK = 9'h108;

	// Control register fields.
	localparam int CTL_EN = 15;
	localparam int CTL_SIZE = 14;
	localparam int CTL_DIR = 13;
	localparam int CTL_HALF = 12;
	localparam int CTL_NULL_WR = 11;
	localparam int CTL_ADDR_MODE_LO = 4;
	localparam int CTL_MODE_LO = 0;
	localparam logic [15:0] CTL_WMASK = 16'hF833;

	localparam logic [1:0] AM_POSTINC = 2'h0;
	localparam logic [1:0] AM_NOINC = 2'h1;
	localparam logic [1:0] AM_PERIPH = 2'h2;
	localparam int MODE_ONESHOT = 0;
	localparam int MODE_PINGPONG = 1;

	// Status 0: block events in 7:0, request overruns in 15:8.
	localparam int ST0_OVR_LO = 8;
	// Status 1: active channel in 2:0, busy in 3, ping-pong selects in 15:8.
	localparam int ST1_BUSY = 3;
	localparam int ST1_PP_LO = 8;

	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
	localparam logic [1:0] BE_LO = 2'h1;
	localparam logic [1:0] BE_HI = 2'h2;
	localparam logic [1:0] BE_WORD = 2'h3;
endpackage : dma_pkg
`default_nettype wire

/* File: verilog/dma_mover.sv */
// Purpose: Moves one element from source to destination bus.
// Assumes: Both buses return read data the cycle after the read strobe.
// Notes: Strobes are single-cycle pulses; done pulses once per element.
`default_nettype none
module dma_mover
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic to_per_i,
	input wire logic byte_i,
	input wire logic null_wr_i,
	input wire logic [15:0] ram_addr_i,
	input wire logic [15:0] per_addr_i,
	input wire logic [15:0] ram_rdata_i,
	input wire logic [15:0] per_rdata_i,
	output logic [15:0] ram_addr_o,
	output logic [15:0] ram_wdata_o,
	output logic [1:0] ram_be_o,
	output logic ram_we_o,
	output logic ram_re_o,
	output logic [15:0] per_addr_o,
	output logic [15:0] per_wdata_o,
	output logic [1:0] per_be_o,
	output logic per_we_o,
	output logic per_re_o,
	output logic done_o
);
	typedef enum logic [2:0] {IDLE, FETCH, CAPTURE, STORE, NULLWR} mv_state_t;

	mv_state_t state_q;
	logic to_per_q;
	logic byte_q;
	logic null_wr_q;

	function automatic logic [1:0] lanes(input logic is_byte, input logic a0);
		lanes = is_byte ? (a0 ? dma_pkg::BE_HI : dma_pkg::BE_LO)
			: dma_pkg::BE_WORD;
	endfunction : lanes

	wire [15:0] src_data = to_per_q ? ram_rdata_i : per_rdata_i;
	wire src_a0 = to_per_q ? ram_addr_o[0] : per_addr_o[0];
	wire [7:0] src_byte = src_a0 ? src_data[15:8] : src_data[7:0];
	wire [15:0] put_data = byte_q ? {src_byte, src_byte} : src_data;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= IDLE;
			{to_per_q, byte_q, null_wr_q} <= 3'h0;
			{ram_addr_o, per_addr_o} <= 32'h0000_0000;
			{ram_wdata_o, per_wdata_o} <= 32'h0000_0000;
			{ram_be_o, per_be_o} <= 4'h0;
			{ram_we_o, ram_re_o, per_we_o, per_re_o, done_o} <= 5'h00;
		end
		else
		begin
			{ram_we_o, ram_re_o, per_we_o, per_re_o, done_o} <= 5'h00;
			case (state_q)
				IDLE:
					if (start_i)
					begin
						to_per_q <= to_per_i;
						byte_q <= byte_i;
						null_wr_q <= null_wr_i & ~to_per_i;
						ram_addr_o <= ram_addr_i;
						per_addr_o <= per_addr_i;
						ram_be_o <= lanes(byte_i, ram_addr_i[0]);
						per_be_o <= lanes(byte_i, per_addr_i[0]);
						ram_re_o <= to_per_i;
						per_re_o <= ~to_per_i;
						state_q <= FETCH;
					end
				FETCH:
					state_q <= CAPTURE;
				CAPTURE:
				begin
					ram_wdata_o <= put_data;
					per_wdata_o <= put_data;
					ram_we_o <= ~to_per_q;
					per_we_o <= to_per_q;
					state_q <= STORE;
				end
				STORE:
					if (null_wr_q)
					begin
						per_wdata_o <= 16'h0000;
						per_we_o <= 1'b1;
						state_q <= NULLWR;
					end
					else
					begin
						done_o <= 1'b1;
						state_q <= IDLE;
					end
				NULLWR:
				begin
					done_o <= 1'b1;
					state_q <= IDLE;
				end
				default:
					state_q <= IDLE;
			endcase
		end
	end
endmodule : dma_mover
`default_nettype wire

/* File: test/dma_channel_control_monitor.sv */
// Purpose: Port checks for the transfer controller.
// Assumes: One clock domain with an active-low asynchronous reset.
// Notes: Bound to every instance of the controller.
`default_nettype none
module dma_channel_control_monitor
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic RAM_WE_O,
	input wire logic RAM_RE_O,
	input wire logic PER_WE_O,
	input wire logic PER_RE_O,
	input wire logic [15:0] PER_WDATA_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	sequence s_req;
		(AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
	endsequence
	sequence s_fill;
		##2 RAM_WE_O;
	endsequence
	sequence s_drain;
		##2 PER_WE_O;
	endsequence
	property p_answer;
		s_req |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
	endproperty
	property p_hi_zero;
		!AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:16] == 16'h0000;
	endproperty
	property p_to_ram;
		PER_RE_O |-> s_fill;
	endproperty
	property p_to_per;
		RAM_RE_O |-> s_drain;
	endproperty
	property p_we_src;
		RAM_WE_O |-> $past(PER_RE_O, 2);
	endproperty
	property p_per_src;
		PER_WE_O |-> $past(RAM_RE_O, 2) || $past(RAM_WE_O);
	endproperty
	property p_one_bus;
		!(PER_RE_O && RAM_RE_O);
	endproperty
	property p_null;
		PER_WE_O && !$past(RAM_RE_O, 2) |-> PER_WDATA_O == 16'h0000;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer late");
	a_hi_zero: assert property (p_hi_zero) else $error("upper half set");
	a_to_ram: assert property (p_to_ram) else $error("no buffer write");
	a_to_per: assert property (p_to_per) else $error("no periph write");
	a_we_src: assert property (p_we_src) else $error("stray buffer write");
	a_per_src: assert property (p_per_src) else $error("stray write");
	a_one_bus: assert property (p_one_bus) else $error("two reads");
	a_null: assert property (p_null) else $error("null data not zero");
endmodule : dma_channel_control_monitor
bind dma_channel_control dma_channel_control_monitor u_mon
(
	.CLK_I(CLK_I), .RST_N_I(RST_N_I), .AVS_READ_I(AVS_READ_I),
	.AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .RAM_WE_O(RAM_WE_O),
	.RAM_RE_O(RAM_RE_O), .PER_WE_O(PER_WE_O), .PER_RE_O(PER_RE_O),
	.PER_WDATA_O(PER_WDATA_O)
);
`default_nettype wire

/* File: test/dma_periph_model.sv */
// Purpose: Peripheral and buffer memory answering read strobes.
// Assumes: Read data must stand in the two cycles after a strobe.
// Notes: Outside that window the data scramble every cycle.
`default_nettype none
module dma_periph_model
(
	input wire logic clk_i,
	input wire logic ram_re_i,
	input wire logic per_re_i,
	input wire logic [15:0] ram_addr_i,
	input wire logic [15:0] per_addr_i,
	output logic [15:0] ram_rdata_o = 16'h0000,
	output logic [15:0] per_rdata_o = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ram_hold_q = 1'b0;
	logic per_hold_q = 1'b0;
	always @(posedge clk_i)
	begin
		ram_hold_q <= ram_re_i;
		per_hold_q <= per_re_i;
		if (ram_re_i)
			ram_rdata_o <= ram_addr_i ^ 16'h5A3C;
		else if (!ram_hold_q)
			ram_rdata_o <= ~ram_rdata_o;
		if (per_re_i)
			per_rdata_o <= per_addr_i ^ 16'h5A3C;
		else if (!per_hold_q)
			per_rdata_o <= ~per_rdata_o;
	end
endmodule : dma_periph_model
`default_nettype wire

/* File: test/dma_channel_control_test.sv */
// Purpose: Self-checking bench for the transfer controller.
// Assumes: A move is over ten cycles after its request.
// Notes: Expected values come from a register and data model kept here.
`default_nettype none
module dma_channel_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_I = 1'b0;
	logic RST_N_I = 1'b0;
	logic [8:0] AVS_ADDRESS_I = 9'h000;
	logic AVS_READ_I = 1'b0;
	logic AVS_WRITE_I = 1'b0;
	logic [31:0] AVS_WRITEDATA_I = 32'h00000000;
	logic [3:0] AVS_BYTEENABLE_I = 4'h0;
	logic [15:0] IRQ_REQ_I = 16'h0000;
	logic [15:0] PERIPH_OFS_I = 16'h0010;
	logic [31:0] AVS_READDATA_O;
	logic [15:0] RAM_RDATA_I, PER_RDATA_I, RAM_ADDR_O, RAM_WDATA_O;
	logic [15:0] PER_ADDR_O, PER_WDATA_O;
	logic [1:0] RAM_BE_O, PER_BE_O;
	logic AVS_WAITREQUEST_O, RAM_WE_O, RAM_RE_O, PER_WE_O, PER_RE_O, INT_O;
	logic [31:0] seed = 32'h00000059;
	logic [15:0] mdl [8][6];
	logic [31:0] ram_q[$], per_q[$], eram[$], eper[$];
	int fail_count = 0;
	int comparisons = 0;
	dma_channel_control u_dut
	(
		.CLK_I(CLK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
		.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
		.AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
		.AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
		.IRQ_REQ_I(IRQ_REQ_I), .PERIPH_OFS_I(PERIPH_OFS_I),
		.RAM_RDATA_I(RAM_RDATA_I), .PER_RDATA_I(PER_RDATA_I),
		.RAM_ADDR_O(RAM_ADDR_O), .RAM_WDATA_O(RAM_WDATA_O), .RAM_BE_O(RAM_BE_O),
		.RAM_WE_O(RAM_WE_O), .RAM_RE_O(RAM_RE_O), .PER_ADDR_O(PER_ADDR_O),
		.PER_WDATA_O(PER_WDATA_O), .PER_BE_O(PER_BE_O), .PER_WE_O(PER_WE_O),
		.PER_RE_O(PER_RE_O), .INT_O(INT_O)
	);
	dma_periph_model u_far
	(
		.clk_i(CLK_I), .ram_re_i(RAM_RE_O), .per_re_i(PER_RE_O),
		.ram_addr_i(RAM_ADDR_O), .per_addr_i(PER_ADDR_O),
		.ram_rdata_o(RAM_RDATA_I), .per_rdata_o(PER_RDATA_I)
	);
	always #25 CLK_I = ~CLK_I;
	always @(posedge CLK_I)
	begin
		if (RAM_WE_O === 1'b1)
			ram_q.push_back({RAM_ADDR_O, RAM_WDATA_O});
		if (PER_WE_O === 1'b1)
			per_q.push_back({PER_ADDR_O, PER_WDATA_O});
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic end_of_test();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic w, input logic [8:0] a,
		input logic [15:0] wd, output logic [15:0] rd);
		int n;
		@(posedge CLK_I);
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= {16'h0000, wd};
		AVS_BYTEENABLE_I <= 4'h3;
		AVS_READ_I <= !w;
		AVS_WRITE_I <= w;
		n = 0;
		do
		begin
			@(posedge CLK_I);
			n++;
		end
		while (AVS_WAITREQUEST_O !== 1'b0 && n < 20);
		if (n >= 20)
		begin
			fail_count++;
			end_of_test();
		end
		rd = AVS_READDATA_O[15:0];
		AVS_READ_I <= 1'b0;
		AVS_WRITE_I <= 1'b0;
	endtask : bus
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		logic [15:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	task automatic rdc(input logic [8:0] a, input logic [15:0] e);
		logic [15:0] x;
		bus(1'b0, a, 16'h0000, x);
		check(x, e);
	endtask : rdc
	task automatic req(input int line, input int n);
		repeat (n)
		begin
			@(posedge CLK_I);
			IRQ_REQ_I <= 16'h0001 << line;
			@(posedge CLK_I);
			IRQ_REQ_I <= 16'h0000;
			repeat (10) @(posedge CLK_I);
		end
	endtask : req
	task automatic setup(input int c, input logic [15:0] sel, sta, stb, pad,
		cnt, ctl);
		wr(9'(c * 32 + 4), sel);
		wr(9'(c * 32 + 8), sta);
		wr(9'(c * 32 + 12), stb);
		wr(9'(c * 32 + 16), pad);
		wr(9'(c * 32 + 20), cnt);
		wr(9'(c * 32), ctl);
	endtask : setup
	task automatic cmpq(ref logic [31:0] got[$], ref logic [31:0] exp[$]);
		check(16'(got.size()), 16'(exp.size()));
		foreach (exp[i])
			if (i < got.size())
			begin
				check(got[i][31:16], exp[i][31:16]);
				check(got[i][15:0], exp[i][15:0]);
			end
		got.delete();
		exp.delete();
	endtask : cmpq
	initial
	begin
		repeat (20000) @(posedge CLK_I);
		fail_count++;
		end_of_test();
	end
	initial
	begin
		logic [15:0] v;
		logic [15:0] p;
		logic [7:0] b;
		repeat (4) @(posedge CLK_I);
		RST_N_I <= 1'b1;
		for (int c = 0; c < 8; c++)
			rdc(9'(c * 32), 16'h0000);
		check({15'h0000, INT_O}, 16'h0000);
		for (int k = 0; k < 48; k++)
		begin
			v = 16'(rnd());
			if (k % 6 == 0)
				v[15] = 1'b0;
			wr(9'(k / 6 * 32 + k % 6 * 4), v);
			mdl[k / 6][k % 6] = v & (k % 6 == 0 ? 16'h7833 :
				k % 6 == 5 ? 16'h03FF : 16'hFFFF);
		end
		for (int k = 0; k < 48; k++)
			rdc(9'(k / 6 * 32 + k % 6 * 4), mdl[k / 6][k % 6]);
		wr(9'h0F8, 16'hFFFF);
		rdc(9'h0F8, 16'h0000);
		rdc(9'h10C, 16'h0000);
		@(posedge CLK_I);
		IRQ_REQ_I <= 16'hFFFF;
		@(posedge CLK_I);
		IRQ_REQ_I <= 16'h0000;
		repeat (12) @(posedge CLK_I);
		check(16'(ram_q.size() + per_q.size()), 16'h0000);
		rdc(9'h100, 16'h0000);
		// Word moves into the buffer, continuous, one reload past the block.
		setup(2, 16'h0005, 16'h0040, 16'h0060, 16'h0200, 16'h0003, 16'h8000);
		for (int i = 0; i < 5; i++)
			eram.push_back({16'(16'h0040 + 2 * (i % 4)), 16'h0200 ^ 16'h5A3C});
		req(5, 5);
		cmpq(ram_q, eram);
		check(PER_ADDR_O, 16'h0200);
		check({14'h0000, RAM_BE_O}, 16'h0003);
		rdc(9'h100, 16'h0004);
		wr(9'h108, 16'h0004);
		repeat (3) @(posedge CLK_I);
		check({15'h0000, INT_O}, 16'h0001);
		wr(9'h100, 16'h0004);
		repeat (3) @(posedge CLK_I);
		check({15'h0000, INT_O}, 16'h0000);
		rdc(9'h100, 16'h0000);
		// Byte moves out of a fixed buffer place, one-shot.
		setup(0, 16'h0003, 16'h0080, 16'h0000, 16'h0300, 16'h0001, 16'hE011);
		b = 8'(16'h0080 ^ 16'h5A3C);
		repeat (2)
			eper.push_back({16'h0300, b, b});
		req(3, 3);
		cmpq(per_q, eper);
		cmpq(ram_q, eram);
		check(RAM_ADDR_O, 16'h0080);
		check({14'h0000, PER_BE_O}, 16'h0001);
		rdc(9'h000, 16'h6011);
		// Peripheral indirect addressing; a two-cycle pulse is two requests.
		wr(9'h040, 16'h8020);
		p = 16'(rnd());
		PERIPH_OFS_I <= p;
		repeat (2)
			eram.push_back({16'(16'h0040 + p), 16'h0200 ^ 16'h5A3C});
		@(posedge CLK_I);
		IRQ_REQ_I <= 16'h0020;
		repeat (2) @(posedge CLK_I);
		IRQ_REQ_I <= 16'h0000;
		repeat (20) @(posedge CLK_I);
		cmpq(ram_q, eram);
		rdc(9'h100, 16'h0401);
		// Ping-pong one-shot with null writes and a half-block event.
		wr(9'h100, 16'hFFFF);
		setup(1, 16'h0007, 16'h0100, 16'h0180, 16'h0400, 16'h0001, 16'h9803);
		req(7, 1);
		rdc(9'h100, 16'h0002);
		req(7, 4);
		for (int i = 0; i < 4; i++)
		begin
			eram.push_back({16'(16'h0100 + 16'h0080 * (i / 2) + 2 * (i % 2)),
				16'h0400 ^ 16'h5A3C});
			eper.push_back({16'h0400, 16'h0000});
		end
		cmpq(ram_q, eram);
		cmpq(per_q, eper);
		rdc(9'h020, 16'h1803);
		rdc(9'h104, 16'h0001);
		end_of_test();
	end
endmodule : dma_channel_control_test
`default_nettype wire
